// >>> doc_debounce.sv
`timescale 1ns/100ps
module doc_debounce import doc_pkg::*; #(
   parameter int N = 5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic [N-1:0] raw,
   output logic [N-1:0] level,
   output logic [N-1:0] rise,
   output logic [N-1:0] fall
);
   logic [N-1:0] meta;
   logic [N-1:0] sync;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= raw;
         sync <= meta;
      end
   end

   // A change must hold for the whole window of ticks before it is believed
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         logic [3:0] cnt;
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cnt <= 4'h0;
               level[i] <= 1'b0;
               rise[i] <= 1'b0;
               fall[i] <= 1'b0;
            end else begin
               rise[i] <= 1'b0;
               fall[i] <= 1'b0;
               if (sync[i] == level[i]) begin
                  cnt <= 4'h0;
               end else if (tick) begin
                  if (cnt == 4'(DEBOUNCE_TICKS - 1)) begin
                     cnt <= 4'h0;
                     level[i] <= sync[i];
                     rise[i] <= sync[i];
                     fall[i] <= ~sync[i];
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end
            end
         end
      end
   endgenerate
endmodule // doc_debounce

// >>> doc_operator_control.sv
`timescale 1ns/100ps
// How it works
// - Two-wire: run while stop/run contact closed
// - Three-wire: start closure runs, stop opening stops
// - Third input as reverse start starts reversed
// - Closed speed-select input picks its reference
// - No speed-select closed means keypad speed
// - Inputs A, B, C select presets one-three
// - Any two presets closed select preset four
// - Input and relay functions follow configuration
// - Program key enters directly or asks password
// - Operator scrolls password, enter compares it
// - Password resets to factory default value
// - Correct password enters program at parameter zero
// - On name, arrows step; enter goes to value
// - On value, arrows step number or cycle choices
// - Only enter commits; old value stays otherwise
// - Program key on value discards edit, back
// - Program key on name leaves program mode
// - Re-entry within two minutes skips password
// - Speed-source key enters or returns to jump
// - Jump arrows step number, caption while stepping
// - Jump enter shows value for normal editing
// - Jump mode only on Modbus variant
// - Highest-lettered closed speed-select input wins unless two presets are closed
// - Terminal start/stop obeyed only in remote
module doc_operator_control import doc_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF,
   parameter int REENTRY_TICKS = REENTRY_TICKS_DEF
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic STOP_RUN_TERMINAL,
   input wire logic START_TERMINAL,
   input wire logic SELECT_INPUT_A,
   input wire logic SELECT_INPUT_B,
   input wire logic SELECT_INPUT_C,
   input wire logic PROGRAM_TOGGLE_KEY,
   input wire logic SPEED_SOURCE_KEY,
   input wire logic KEY_ENTER,
   input wire logic KEY_UP,
   input wire logic KEY_DOWN,
   input doc_cfg_s CONFIG,
   output logic RUN,
   output logic REVERSE,
   output doc_src_e SPEED_SOURCE,
   output logic RELAY_OUT,
   output logic PROGRAM_MODE,
   output logic PASSWORD_PROMPT,
   output logic CURSOR_ON_VALUE,
   output logic PARAMETER_JUMP_MODE,
   output logic JUMP_CAPTION,
   output logic [5:0] PARAM_NUMBER,
   output logic [15:0] DISPLAY_VALUE
);
   logic [15:0] tick_cnt;
   logic tick;
   logic [4:0] c_lvl, c_rise, c_fall;
   logic [4:0] k_lvl, k_rise;
   logic rev_en;
   logic [1:0] preset_cnt;
   doc_src_e next_src;
   doc_state_e state, next_state;
   logic [5:0] param, next_param;
   logic [15:0] edit, next_edit;
   logic [15:0] entry, next_entry;
   logic [15:0] password;
   logic [15:0] rd_data;
   logic [16:0] window_cnt;
   logic window;
   logic exit_prog;
   logic jump_ok;
   doc_wr_s wr;

   // Millisecond enable; all slow timing counts these pulses
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tick_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
      end
   end

   doc_debounce #(.N(5)) u_contacts (
      .clk(CLK),
      .resetn(RESETN),
      .tick(tick),
      .raw({SELECT_INPUT_C, SELECT_INPUT_B, SELECT_INPUT_A, START_TERMINAL, STOP_RUN_TERMINAL}),
      .level(c_lvl),
      .rise(c_rise),
      .fall(c_fall)
   );

   doc_debounce #(.N(5)) u_keys (
      .clk(CLK),
      .resetn(RESETN),
      .tick(tick),
      .raw({KEY_DOWN, KEY_UP, KEY_ENTER, SPEED_SOURCE_KEY, PROGRAM_TOGGLE_KEY}),
      .level(k_lvl),
      .rise(k_rise),
      .fall()
   );

   doc_param_store u_store (
      .clk(CLK),
      .resetn(RESETN),
      .wr(wr),
      .rd_addr(param),
      .rd_data(rd_data)
   );

   // Start/stop from the terminal strip
   assign rev_en = (CONFIG.sel_c == SF_START_REV);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RUN <= 1'b0;
         REVERSE <= 1'b0;
      end else if (CONFIG.remote) begin
         if (!CONFIG.three_wire) begin
            RUN <= c_lvl[C_STOP];
            REVERSE <= rev_en & c_lvl[C_C];
         end else if (!c_lvl[C_STOP] || c_fall[C_STOP]) begin
            RUN <= 1'b0;
         end else if (rev_en && c_rise[C_C]) begin
            RUN <= 1'b1;
            REVERSE <= 1'b1;
         end else if (c_rise[C_START]) begin
            RUN <= 1'b1;
            REVERSE <= 1'b0;
         end
      end
   end

   // Speed reference choice
   function automatic doc_src_e src_of(input doc_sel_func_e f, input doc_src_e preset);
      case (f)
         SF_VOLT: src_of = SRC_VOLT;
         SF_MA: src_of = SRC_MA;
         default: src_of = preset;
      endcase
   endfunction

   assign preset_cnt = 2'((c_lvl[C_A] && CONFIG.sel_a == SF_PRESET))
                     + 2'((c_lvl[C_B] && CONFIG.sel_b == SF_PRESET))
                     + 2'((c_lvl[C_C] && CONFIG.sel_c == SF_PRESET));

   always_comb begin
      if (preset_cnt >= 2'h2) begin
         next_src = SRC_PRESET4;
      end else if (c_lvl[C_C] && is_speed_ref(CONFIG.sel_c)) begin
         next_src = src_of(CONFIG.sel_c, SRC_PRESET3);
      end else if (c_lvl[C_B] && is_speed_ref(CONFIG.sel_b)) begin
         next_src = src_of(CONFIG.sel_b, SRC_PRESET2);
      end else if (c_lvl[C_A] && is_speed_ref(CONFIG.sel_a)) begin
         next_src = src_of(CONFIG.sel_a, SRC_PRESET1);
      end else begin
         next_src = SRC_KEYPAD;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SPEED_SOURCE <= SRC_KEYPAD;
      end else begin
         SPEED_SOURCE <= next_src;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RELAY_OUT <= 1'b0;
      end else begin
         case (CONFIG.relay)
            RL_RUN: RELAY_OUT <= RUN;
            RL_REVERSE: RELAY_OUT <= REVERSE;
            RL_AUTO: RELAY_OUT <= (SPEED_SOURCE != SRC_KEYPAD);
            default: RELAY_OUT <= PROGRAM_MODE;
         endcase
      end
   end

   // Keypad programming
   function automatic logic [15:0] value_step(input logic [15:0] v, input logic [15:0] mx, input logic up);
      if (mx != VALUE_NUMERIC) begin
         if (up) value_step = (v >= mx) ? 16'h0000 : v + 16'h0001;
         else value_step = (v == 16'h0000) ? mx : v - 16'h0001;
      end else begin
         if (up) value_step = (v == mx) ? v : v + 16'h0001;
         else value_step = (v == 16'h0000) ? v : v - 16'h0001;
      end
   endfunction

   assign jump_ok = CONFIG.modbus;
   assign window = (window_cnt != 17'h0_0000);

   always_comb begin
      next_state = state;
      next_param = param;
      next_edit = edit;
      next_entry = entry;
      wr = '0;
      exit_prog = 1'b0;
      case (state)
         ST_IDLE: begin
            if (k_rise[K_PROG]) begin
               if (!CONFIG.pw_enable || window) begin
                  next_state = ST_NAME;
                  next_param = window ? param : PARAM_FIRST;
               end else begin
                  next_state = ST_PASSWORD;
                  next_entry = 16'h0000;
               end
            end
         end
         ST_PASSWORD: begin
            if (k_rise[K_PROG]) begin
               next_state = ST_IDLE;
            end else if (k_rise[K_ENTER]) begin
               if (entry == password) begin
                  next_state = ST_NAME;
                  next_param = PARAM_FIRST;
               end else begin
                  next_state = ST_IDLE;
               end
            end else if (k_rise[K_UP]) begin
               next_entry = entry + 16'h0001;
            end else if (k_rise[K_DOWN]) begin
               next_entry = entry - 16'h0001;
            end
         end
         ST_NAME: begin
            if (k_rise[K_PROG]) begin
               next_state = ST_IDLE;
               exit_prog = 1'b1;
            end else if (k_rise[K_SRC] && jump_ok) begin
               next_state = ST_JUMP;
            end else if (k_rise[K_ENTER]) begin
               next_state = ST_VALUE;
               next_edit = rd_data;
            end else if (k_rise[K_UP]) begin
               next_param = param + 6'h01;
            end else if (k_rise[K_DOWN]) begin
               next_param = param - 6'h01;
            end
         end
         ST_VALUE: begin
            if (k_rise[K_PROG]) begin
               next_state = ST_NAME;
            end else if (k_rise[K_SRC] && jump_ok) begin
               next_state = ST_JUMP;
            end else if (k_rise[K_ENTER]) begin
               wr = '{en: 1'b1, addr: param, data: edit};
               next_state = ST_NAME;
            end else if (k_rise[K_UP]) begin
               next_edit = value_step(edit, param_max(param), 1'b1);
            end else if (k_rise[K_DOWN]) begin
               next_edit = value_step(edit, param_max(param), 1'b0);
            end
         end
         ST_JUMP: begin
            if (!jump_ok || k_rise[K_PROG]) begin
               next_state = ST_NAME;
            end else if (k_rise[K_ENTER]) begin
               next_state = ST_VALUE;
               next_edit = rd_data;
            end else if (k_rise[K_UP]) begin
               next_param = param + 6'h01;
            end else if (k_rise[K_DOWN]) begin
               next_param = param - 6'h01;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_IDLE;
         param <= PARAM_FIRST;
         edit <= VALUE_RESET;
         entry <= VALUE_RESET;
      end else begin
         state <= next_state;
         param <= next_param;
         edit <= next_edit;
         entry <= next_entry;
      end
   end

   // The password lives outside the table so a cleared store cannot unlock the keypad
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         password <= PASSWORD_RESET;
      end else if (wr.en && wr.addr == PARAM_PASSWORD) begin
         password <= wr.data;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         window_cnt <= 17'h0_0000;
      end else if (exit_prog) begin
         window_cnt <= 17'(REENTRY_TICKS);
      end else if (tick && window) begin
         window_cnt <= window_cnt - 17'h0_0001;
      end
   end

   // Display reads the table one cycle behind the parameter number
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PROGRAM_MODE <= 1'b0;
         PASSWORD_PROMPT <= 1'b0;
         CURSOR_ON_VALUE <= 1'b0;
         PARAMETER_JUMP_MODE <= 1'b0;
         JUMP_CAPTION <= 1'b0;
         PARAM_NUMBER <= PARAM_FIRST;
         DISPLAY_VALUE <= VALUE_RESET;
      end else begin
         PROGRAM_MODE <= (next_state != ST_IDLE);
         PASSWORD_PROMPT <= (next_state == ST_PASSWORD);
         CURSOR_ON_VALUE <= (next_state == ST_VALUE);
         PARAMETER_JUMP_MODE <= (next_state == ST_JUMP);
         JUMP_CAPTION <= (next_state == ST_JUMP) && (k_lvl[K_UP] || k_lvl[K_DOWN]);
         PARAM_NUMBER <= next_param;
         DISPLAY_VALUE <= (next_state == ST_PASSWORD) ? next_entry :
                          (next_state == ST_VALUE) ? next_edit : rd_data;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   a_two_wire_run: assert property (CONFIG.remote && !CONFIG.three_wire |=> RUN == $past(c_lvl[C_STOP]))
      else $error("two-wire run does not follow stop/run contact");
   a_three_stop: assert property (CONFIG.remote && CONFIG.three_wire && c_fall[C_STOP] |=> !RUN)
      else $error("three-wire stop opening did not stop");
   a_reverse_start: assert property (CONFIG.remote && CONFIG.three_wire && rev_en && c_rise[C_C] && c_lvl[C_STOP]
      |=> RUN && REVERSE)
      else $error("reverse start not obeyed");
   a_local_hold: assert property (!CONFIG.remote |=> $stable(RUN))
      else $error("run changed outside remote mode");
   a_keypad_fallback: assert property (!(c_lvl[C_A] || c_lvl[C_B] || c_lvl[C_C]) |=> SPEED_SOURCE == SRC_KEYPAD)
      else $error("no selection but speed not from keypad");
   a_preset_four: assert property (preset_cnt >= 2'h2 |=> SPEED_SOURCE == SRC_PRESET4)
      else $error("two presets closed but not preset four");
   a_highest_wins: assert property (c_lvl[C_C] && CONFIG.sel_c == SF_VOLT && preset_cnt < 2'h2
      |=> SPEED_SOURCE == SRC_VOLT)
      else $error("input C did not override");
   a_password_gate: assert property (state == ST_IDLE && k_rise[K_PROG] && CONFIG.pw_enable && !window
      |=> PASSWORD_PROMPT && state == ST_PASSWORD)
      else $error("password prompt missing");
   a_password_ok: assert property (state == ST_PASSWORD && !k_rise[K_PROG] && k_rise[K_ENTER] && entry == password
      |=> state == ST_NAME && PARAM_NUMBER == 6'h00)
      else $error("correct password not accepted at parameter zero");
   a_commit_cancel: assert property (state == ST_VALUE && k_rise[K_PROG] |-> !wr.en ##1 state == ST_NAME)
      else $error("cancel wrote or did not return to name");
   a_reentry_open: assert property (state == ST_NAME && k_rise[K_PROG]
      |=> state == ST_IDLE && window_cnt == 17'(REENTRY_TICKS))
      else $error("exit did not open re-entry window");
   a_jump_variant: assert property (!CONFIG.modbus && state != ST_JUMP |=> state != ST_JUMP)
      else $error("jump mode entered without modbus");

   c_three_wire_run: cover property (CONFIG.three_wire && c_rise[C_START] ##1 RUN);
   c_commit: cover property (wr.en ##1 state == ST_NAME);
   c_reentry: cover property (state == ST_IDLE && window && k_rise[K_PROG] ##1 state == ST_NAME);
   c_jump_edit: cover property (state == ST_JUMP ##1 state == ST_VALUE);
endmodule // doc_operator_control

// >>> doc_operator_control_tb.sv
`timescale 1ns/100ps
module doc_operator_control_tb import doc_pkg::*;;
   logic clk;
   logic resetn;
   doc_cfg_s cfg;
   logic [4:0] contact;
   logic [4:0] key;
   logic run;
   logic reverse;
   doc_src_e src;
   logic relay_out;
   logic prog_mode;
   logic pw_prompt;
   logic on_value;
   logic jump;
   logic caption;
   logic [5:0] param_num;
   logic [15:0] disp;
   int bad_count;
   int compares;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   doc_operator_model i_op (.clk(clk), .contact(contact), .key(key));

   // Short tick and window keep the run brief; the fixed cycle waits are sized to them
   doc_operator_control #(.TICK_CYCLES(4), .REENTRY_TICKS(100)) i_dut (
      .CLK(clk), .RESETN(resetn),
      .STOP_RUN_TERMINAL(contact[C_STOP]), .START_TERMINAL(contact[C_START]),
      .SELECT_INPUT_A(contact[C_A]), .SELECT_INPUT_B(contact[C_B]), .SELECT_INPUT_C(contact[C_C]),
      .PROGRAM_TOGGLE_KEY(key[K_PROG]), .SPEED_SOURCE_KEY(key[K_SRC]),
      .KEY_ENTER(key[K_ENTER]), .KEY_UP(key[K_UP]), .KEY_DOWN(key[K_DOWN]),
      .CONFIG(cfg), .RUN(run), .REVERSE(reverse), .SPEED_SOURCE(src), .RELAY_OUT(relay_out),
      .PROGRAM_MODE(prog_mode), .PASSWORD_PROMPT(pw_prompt), .CURSOR_ON_VALUE(on_value),
      .PARAMETER_JUMP_MODE(jump), .JUMP_CAPTION(caption), .PARAM_NUMBER(param_num),
      .DISPLAY_VALUE(disp)
   );

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic speed(input logic [2:0] m, input doc_src_e e);
      i_op.set_sel(m);
      check(src, e, "speed source");
   endtask

   task automatic conclude;
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      conclude;
   end

   initial begin
      resetn = 1'b0;
      cfg = '0;
      bad_count = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      check(run, 1'b0, "run at reset");
      check(src, SRC_KEYPAD, "source at reset");
      @(posedge clk);
      cfg.remote <= 1'b1;
      cfg.relay <= RL_RUN;
      i_op.set_contact(C_STOP, 1'b1);
      check(run, 1'b1, "two-wire run");
      check(relay_out, 1'b1, "relay on run");
      i_op.set_contact(C_STOP, 1'b0);
      check(run, 1'b0, "two-wire stop");
      @(posedge clk);
      cfg.remote <= 1'b0;
      i_op.set_contact(C_STOP, 1'b1);
      check(run, 1'b0, "local ignores strip");
      @(posedge clk);
      cfg.remote <= 1'b1;
      cfg.three_wire <= 1'b1;
      i_op.glitch(C_START);
      check(run, 1'b0, "bounce ignored");
      i_op.set_contact(C_START, 1'b1);
      check(run, 1'b1, "three-wire start");
      check(reverse, 1'b0, "forward start");
      i_op.set_contact(C_START, 1'b0);
      check(run, 1'b1, "start is momentary");
      i_op.set_contact(C_STOP, 1'b0);
      check(run, 1'b0, "three-wire stop");
      check(relay_out, 1'b0, "relay off");
      i_op.set_contact(C_STOP, 1'b1);
      @(posedge clk);
      cfg.sel_c <= SF_START_REV;
      i_op.set_contact(C_C, 1'b1);
      check(run, 1'b1, "reverse start");
      check(reverse, 1'b1, "reverse dir");
      @(posedge clk);
      cfg.relay <= RL_REVERSE;
      i_op.wait_cycles(3);
      check(relay_out, 1'b1, "relay on reverse");
      i_op.set_contact(C_C, 1'b0);
      i_op.set_contact(C_STOP, 1'b0);
      check(run, 1'b0, "stop after reverse");
      @(posedge clk);
      cfg.sel_a <= SF_PRESET;
      cfg.sel_b <= SF_PRESET;
      cfg.sel_c <= SF_PRESET;
      cfg.relay <= RL_AUTO;
      speed(3'b001, SRC_PRESET1);
      check(relay_out, 1'b1, "relay on auto");
      speed(3'b010, SRC_PRESET2);
      speed(3'b100, SRC_PRESET3);
      speed(3'b011, SRC_PRESET4);
      speed(3'b110, SRC_PRESET4);
      speed(3'b000, SRC_KEYPAD);
      check(relay_out, 1'b0, "relay off on keypad");
      @(posedge clk);
      cfg.sel_a <= SF_MA;
      cfg.sel_c <= SF_VOLT;
      speed(3'b001, SRC_MA);
      speed(3'b011, SRC_PRESET2);
      speed(3'b101, SRC_VOLT);
      speed(3'b000, SRC_KEYPAD);
      @(posedge clk);
      cfg.pw_enable <= 1'b1;
      cfg.modbus <= 1'b1;
      cfg.relay <= RL_PROGRAM;
      i_op.press(K_PROG, 1);
      check(prog_mode, 1'b1, "prompt entry");
      check(pw_prompt, 1'b1, "prompt shown");
      check(relay_out, 1'b1, "relay on program");
      i_op.enter_password(18);
      check(prog_mode, 1'b0, "wrong password");
      i_op.press(K_PROG, 1);
      i_op.enter_password(19);
      check(pw_prompt, 1'b0, "default password");
      check(prog_mode, 1'b1, "program entered");
      check(param_num, 6'h00, "first parameter");
      i_op.press(K_ENTER, 1);
      check(on_value, 1'b1, "cursor on value");
      i_op.press(K_UP, 3);
      check(disp, 16'h0000, "choice wraps");
      i_op.press(K_PROG, 1);
      check(on_value, 1'b0, "back to name");
      i_op.press(K_UP, 1);
      check(param_num, 6'h01, "next parameter");
      i_op.press(K_ENTER, 1);
      i_op.press(K_UP, 2);
      check(disp, 16'h0002, "increment");
      i_op.press(K_DOWN, 1);
      check(disp, 16'h0001, "decrement");
      i_op.press(K_PROG, 1);
      check(disp, 16'h0000, "edit discarded");
      i_op.press(K_ENTER, 1);
      i_op.press(K_UP, 3);
      i_op.press(K_ENTER, 1);
      check(on_value, 1'b0, "commit to name");
      check(disp, 16'h0003, "value committed");
      i_op.press(K_PROG, 1);
      check(prog_mode, 1'b0, "program exit");
      i_op.press(K_PROG, 1);
      check(prog_mode, 1'b1, "reentry entered");
      check(pw_prompt, 1'b0, "reentry no password");
      check(param_num, 6'h01, "last parameter");
      i_op.press(K_PROG, 1);
      i_op.wait_cycles(450);
      i_op.press(K_PROG, 1);
      check(pw_prompt, 1'b1, "window expired");
      i_op.press(K_PROG, 1);
      @(posedge clk);
      cfg.pw_enable <= 1'b0;
      i_op.press(K_PROG, 1);
      check(prog_mode, 1'b1, "direct entry");
      check(pw_prompt, 1'b0, "no prompt");
      i_op.press(K_SRC, 1);
      check(jump, 1'b1, "jump mode");
      i_op.hold_key(K_UP, 1'b1);
      check(caption, 1'b1, "caption while stepping");
      i_op.hold_key(K_UP, 1'b0);
      check(caption, 1'b0, "name after step");
      check(param_num, 6'h01, "jump step");
      i_op.press(K_ENTER, 1);
      check(on_value, 1'b1, "jump edit");
      check(disp, 16'h0003, "jump setting");
      i_op.press(K_SRC, 1);
      check(jump, 1'b1, "back to jump");
      @(posedge clk);
      cfg.modbus <= 1'b0;
      i_op.wait_cycles(5);
      check(jump, 1'b0, "jump leaves");
      i_op.press(K_SRC, 1);
      check(jump, 1'b0, "jump absent");
      conclude;
   end
endmodule // doc_operator_control_tb

// >>> doc_operator_model.sv
`timescale 1ns/100ps
module doc_operator_model import doc_pkg::*; (
   input wire logic clk,
   output logic [4:0] contact,
   output logic [4:0] key
);
   // Held well past the debounce window so every action is seen exactly once
   localparam int HOLD = 60;

   initial begin
      contact = '0;
      key = '0;
   end

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic set_contact(input int idx, input logic v);
      @(posedge clk);
      contact[idx] <= v;
      wait_cycles(HOLD);
   endtask

   task automatic set_sel(input logic [2:0] m);
      @(posedge clk);
      contact[C_C:C_A] <= m;
      wait_cycles(HOLD);
   endtask

   // Bounce shorter than the debounce window; must leave no trace
   task automatic glitch(input int idx);
      @(posedge clk);
      contact[idx] <= ~contact[idx];
      wait_cycles(5);
      contact[idx] <= ~contact[idx];
      wait_cycles(HOLD);
   endtask

   task automatic hold_key(input int idx, input logic v);
      @(posedge clk);
      key[idx] <= v;
      wait_cycles(HOLD);
   endtask

   task automatic press(input int idx, input int times);
      for (int i = 0; i < times; i++) begin
         hold_key(idx, 1'b1);
         hold_key(idx, 1'b0);
      end
   endtask

   // Operator scrolls up from zero, then confirms
   task automatic enter_password(input int steps);
      press(K_UP, steps);
      press(K_ENTER, 1);
   endtask
endmodule // doc_operator_model

// >>> doc_param_store.sv
`timescale 1ns/100ps
module doc_param_store import doc_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input doc_wr_s wr,
   input wire logic [5:0] rd_addr,
   output logic [15:0] rd_data
);
   logic [15:0] mem [PARAM_COUNT];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int j = 0; j < PARAM_COUNT; j++) begin
            mem[j] <= VALUE_RESET;
         end
      end else if (wr.en) begin
         mem[wr.addr] <= wr.data;
      end
   end

   assign rd_data = mem[rd_addr];
endmodule // doc_param_store

// >>> doc_pkg.sv
package doc_pkg;

   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
   localparam int REENTRY_S = 120;
   localparam int REENTRY_TICKS_DEF = REENTRY_S * 1_000_000 / TICK_US;

   // Parameter table
   localparam int PARAM_COUNT = 64;
   localparam logic [5:0] PARAM_FIRST = 6'h00;
   localparam logic [5:0] PARAM_PASSWORD = 6'h3F;
   localparam logic [15:0] PASSWORD_RESET = 16'h0013;
   localparam logic [15:0] VALUE_NUMERIC = 16'hFFFF;
   localparam logic [15:0] VALUE_RESET = 16'h0000;

   // Bit positions inside the debounced groups
   localparam int C_STOP = 0;
   localparam int C_START = 1;
   localparam int C_A = 2;
   localparam int C_B = 3;
   localparam int C_C = 4;
   localparam int K_PROG = 0;
   localparam int K_SRC = 1;
   localparam int K_ENTER = 2;
   localparam int K_UP = 3;
   localparam int K_DOWN = 4;

   typedef enum logic [2:0] {
      SF_NONE = 3'h0,
      SF_VOLT = 3'h1,
      SF_MA = 3'h2,
      SF_PRESET = 3'h3,
      SF_START_REV = 3'h4
   } doc_sel_func_e;

   typedef enum logic [2:0] {
      SRC_KEYPAD = 3'h0,
      SRC_VOLT = 3'h1,
      SRC_MA = 3'h2,
      SRC_PRESET1 = 3'h3,
      SRC_PRESET2 = 3'h4,
      SRC_PRESET3 = 3'h5,
      SRC_PRESET4 = 3'h6
   } doc_src_e;

   typedef enum logic [1:0] {
      RL_RUN = 2'h0,
      RL_REVERSE = 2'h1,
      RL_AUTO = 2'h2,
      RL_PROGRAM = 2'h3
   } doc_relay_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PASSWORD = 3'b001,
      ST_NAME = 3'b011,
      ST_VALUE = 3'b010,
      ST_JUMP = 3'b110
   } doc_state_e;

   typedef struct packed {
      doc_sel_func_e sel_a;
      doc_sel_func_e sel_b;
      doc_sel_func_e sel_c;
      doc_relay_e relay;
      logic three_wire;
      logic remote;
      logic pw_enable;
      logic modbus;
   } doc_cfg_s;

   typedef struct packed {
      logic en;
      logic [5:0] addr;
      logic [15:0] data;
   } doc_wr_s;

   // Upper bound of a choice-type parameter; numeric ones saturate at all ones
   function automatic logic [15:0] param_max(input logic [5:0] num);
      case (num)
         6'h00: param_max = 16'h0002;
         6'h0E: param_max = 16'h0001;
         6'h16: param_max = 16'h0002;
         6'h19: param_max = 16'h0004;
         6'h1A: param_max = 16'h0002;
         6'h1C: param_max = 16'h0003;
         6'h1E: param_max = 16'h0005;
         default: param_max = VALUE_NUMERIC;
      endcase
   endfunction

   function automatic logic is_speed_ref(input doc_sel_func_e f);
      is_speed_ref = (f == SF_VOLT) || (f == SF_MA) || (f == SF_PRESET);
   endfunction

endpackage
